//--- core/ppc_consts.vh
// Constants shared by the payload primitive codec
`ifndef PPC_CONSTS_VH
`define PPC_CONSTS_VH

// ****************************************
// Element type codes
// ****************************************
`define PPC_T_S32    3'h0
`define PPC_T_S64    3'h1
`define PPC_T_F32    3'h2
`define PPC_T_F64    3'h3
`define PPC_T_BOOL   3'h4
`define PPC_T_PBOOL  3'h5
`define PPC_T_STR    3'h6
`define PPC_T_CHAR   3'h7

// ****************************************
// Byte counts and packed Boolean limit
// ****************************************
`define PPC_N_WORD   4'h4
`define PPC_N_DWORD  4'h8
`define PPC_N_LEN    4'h2
`define PPC_N_CHAR   4'h1
`define PPC_BOOL_MAX 6'h20

// ****************************************
// Register map and fields
// ****************************************
`define PPC_A_CTRL   5'h00
`define PPC_A_SSIZE  5'h04
`define PPC_A_STAT   5'h08
`define PPC_A_ECNT   5'h0C
`define PPC_A_DCNT   5'h10
`define PPC_B_ENC_EN 0
`define PPC_B_DEC_EN 1
`define PPC_B_EBUSY  0
`define PPC_B_DBUSY  1
`define PPC_B_EERR   8
`define PPC_B_DERR   9
`define PPC_CTRL_RST 2'h3
`define PPC_SSIZE_RST 16'h0020
`define PPC_RESP_OK  2'h0
`define PPC_RESP_ERR 2'h2

`endif

//--- core/ppc_codec.v
// Payload primitive codec: typed elements to big-endian payload bytes and back
`timescale 1ns/10ps
`include "ppc_consts.vh"

// Function
// - 32-bit integers are two's complement, msb bit 31, lsb bit 0.
// - 64-bit integers are two's complement over bits 63..0, upper then lower word.
// - Float elements pass unchanged in standard binary layout.
// - Float msb is sign: 0 positive, 1 negative.
// - Single float: sign, 8-bit exponent, 23-bit fraction.
// - Double float: sign, 11-bit exponent, 52-bit fraction.
// - Decoded fraction gets hidden one if normalized, zero if denormalized.
// - No scaling of integer or float values ever.
// - Lone Boolean uses a 32-bit field, value in bit 0.
// - Boolean bit 1 is true, 0 is false.
// - At most 32 packed Booleans per word; a larger count is clamped to 32.
// - Packed Booleans fill from lsb toward msb.
// - Unused packed Boolean bits at the top are zero.
// - String carries one ASCII character per byte, in order.
// - String starts with 2-byte unsigned length, characters follow.
// - Multi-byte values go most significant byte first.
// - String has fixed size; bytes after characters are zero.
module ppc_codec (
   input  wire        aclk,
   input  wire        aresetn,
   input  wire [4:0]  s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output wire        s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output wire        s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [4:0]  s_axi_araddr,
   input  wire        s_axi_arvalid,
   output wire        s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   input  wire        in_valid,
   output wire        in_ready,
   input  wire [2:0]  in_type,
   input  wire [63:0] in_data,
   input  wire [5:0]  in_bool_count,
   output wire        tx_valid,
   input  wire        tx_ready,
   output wire [7:0]  tx_byte,
   output wire        tx_last,
   input  wire        rx_valid,
   output wire        rx_ready,
   input  wire [7:0]  rx_byte,
   input  wire [2:0]  dec_type,
   output wire        out_valid,
   input  wire        out_ready,
   output reg  [2:0]  out_type,
   output reg  [63:0] out_data,
   output reg         out_sign,
   output reg  [10:0] out_exp,
   output reg  [52:0] out_frac,
   output reg         out_bool,
   output wire        out_last
);

   // ****************************************
   // Registers over the bus
   // ****************************************
   reg  [1:0]  ctrl_reg;
   reg  [15:0] ssize_reg;
   reg         eerr_reg;
   reg         derr_reg;
   reg  [31:0] ecnt_reg;
   reg  [31:0] dcnt_reg;
   reg  [4:0]  awaddr_reg;
   reg         aw_got_reg;
   reg  [31:0] wdata_reg;
   reg  [3:0]  wstrb_reg;
   reg         w_got_reg;
   wire        enc_en = ctrl_reg[`PPC_B_ENC_EN];
   wire        dec_en = ctrl_reg[`PPC_B_DEC_EN];
   wire        do_wr  = aw_got_reg & w_got_reg & ~s_axi_bvalid;
   wire        eerr_set;
   wire        derr_set;
   wire        enc_done;
   wire        dec_done;
   wire        e_busy;
   wire        d_busy;

   assign s_axi_awready = ~aw_got_reg & ~s_axi_bvalid;
   assign s_axi_wready  = ~w_got_reg & ~s_axi_bvalid;
   assign s_axi_arready = ~s_axi_rvalid;

   function [31:0] merge;
      input [31:0] old;
      input [31:0] nw;
      input [3:0]  st;
      integer      i;
      begin
         merge = old;
         for (i = 0; i < 4; i = i + 1) begin
            if (st[i]) begin
               merge[i*8 +: 8] = nw[i*8 +: 8];
            end
         end
      end
   endfunction

   wire [31:0] ctrl_m  = merge({30'h0, ctrl_reg}, wdata_reg, wstrb_reg);
   wire [31:0] ssize_m = merge({16'h0, ssize_reg}, wdata_reg, wstrb_reg);
   wire [31:0] stat_w  = merge(32'h0, wdata_reg, wstrb_reg);
   wire        wr_stat = do_wr & (awaddr_reg == `PPC_A_STAT);
   wire        wr_map  = (awaddr_reg <= `PPC_A_DCNT);

   always @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_reg     <= `PPC_CTRL_RST;
         ssize_reg    <= `PPC_SSIZE_RST;
         eerr_reg     <= 1'b0;
         derr_reg     <= 1'b0;
         ecnt_reg     <= 32'h0;
         dcnt_reg     <= 32'h0;
         awaddr_reg   <= 5'h00;
         aw_got_reg   <= 1'b0;
         wdata_reg    <= 32'h0;
         wstrb_reg    <= 4'h0;
         w_got_reg    <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `PPC_RESP_OK;
         s_axi_rvalid <= 1'b0;
         s_axi_rresp  <= `PPC_RESP_OK;
         s_axi_rdata  <= 32'h0;
      end else begin
         if (s_axi_awvalid & s_axi_awready) begin
            awaddr_reg <= {s_axi_awaddr[4:2], 2'h0};
            aw_got_reg <= 1'b1;
         end
         if (s_axi_wvalid & s_axi_wready) begin
            wdata_reg <= s_axi_wdata;
            wstrb_reg <= s_axi_wstrb;
            w_got_reg <= 1'b1;
         end
         if (do_wr) begin
            aw_got_reg   <= 1'b0;
            w_got_reg    <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_map ? `PPC_RESP_OK : `PPC_RESP_ERR;
            if (awaddr_reg == `PPC_A_CTRL) begin
               ctrl_reg <= ctrl_m[1:0];
            end
            if (awaddr_reg == `PPC_A_SSIZE) begin
               ssize_reg <= ssize_m[15:0];
            end
         end else if (s_axi_bvalid & s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         // Sticky errors: a new event wins over a write-one-to-clear
         eerr_reg <= eerr_set | (eerr_reg & ~(wr_stat & stat_w[`PPC_B_EERR]));
         derr_reg <= derr_set | (derr_reg & ~(wr_stat & stat_w[`PPC_B_DERR]));
         ecnt_reg <= ecnt_reg + {31'h0, enc_done};
         dcnt_reg <= dcnt_reg + {31'h0, dec_done};
         if (s_axi_arvalid & s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= `PPC_RESP_OK;
            case ({s_axi_araddr[4:2], 2'h0})
               `PPC_A_CTRL:  s_axi_rdata <= {30'h0, ctrl_reg};
               `PPC_A_SSIZE: s_axi_rdata <= {16'h0, ssize_reg};
               `PPC_A_STAT:  s_axi_rdata <= {22'h0, derr_reg, eerr_reg, 6'h0, d_busy, e_busy};
               `PPC_A_ECNT:  s_axi_rdata <= ecnt_reg;
               `PPC_A_DCNT:  s_axi_rdata <= dcnt_reg;
               default: begin
                  s_axi_rdata <= 32'h0;
                  s_axi_rresp <= `PPC_RESP_ERR;
               end
            endcase
         end else if (s_axi_rvalid & s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // ****************************************
   // Encoder
   // ****************************************
   localparam E_IDLE  = 4'h1;
   localparam E_SHIFT = 4'h2;
   localparam E_CHAR  = 4'h4;
   localparam E_PAD   = 4'h8;

   reg  [3:0]  e_state_reg;
   reg  [63:0] e_sh_reg;
   reg  [3:0]  e_cnt_reg;
   reg         e_str_reg;
   reg  [15:0] e_chars_reg;
   reg  [15:0] e_pad_reg;
   wire        in_take = in_valid & in_ready;
   wire [5:0]  bcnt    = (in_bool_count > `PPC_BOOL_MAX) ? `PPC_BOOL_MAX : in_bool_count;
   wire [31:0] pmask   = (bcnt == `PPC_BOOL_MAX) ? 32'hFFFFFFFF :
                         ((32'h1 << bcnt) - 32'h1);
   wire        e_long  = in_data[15:0] > ssize_reg;
   wire [15:0] e_len   = e_long ? ssize_reg : in_data[15:0];
   wire        e_more  = e_str_reg & ((e_chars_reg != 16'h0) | (e_pad_reg != 16'h0));
   wire        e_lastb = (e_state_reg == E_SHIFT) & (e_cnt_reg == 4'h1);

   assign in_ready = enc_en & ((e_state_reg == E_IDLE) |
                     ((e_state_reg == E_CHAR) & (in_type == `PPC_T_CHAR)));
   assign tx_valid = (e_state_reg == E_SHIFT) | (e_state_reg == E_PAD);
   assign tx_byte  = e_sh_reg[63:56];
   assign tx_last  = (e_lastb & ~e_more) | ((e_state_reg == E_PAD) & (e_pad_reg == 16'h1));
   assign enc_done = tx_valid & tx_ready & tx_last;
   assign eerr_set = in_take & (e_state_reg == E_IDLE) & (in_type == `PPC_T_STR) & e_long;
   assign e_busy   = (e_state_reg != E_IDLE);

   always @(posedge aclk) begin
      if (!aresetn) begin
         e_state_reg <= E_IDLE;
         e_sh_reg    <= 64'h0;
         e_cnt_reg   <= 4'h0;
         e_str_reg   <= 1'b0;
         e_chars_reg <= 16'h0;
         e_pad_reg   <= 16'h0;
      end else begin
         case (e_state_reg)
            E_IDLE: begin
               if (in_take) begin
                  e_str_reg   <= 1'b0;
                  e_state_reg <= E_SHIFT;
                  e_cnt_reg   <= `PPC_N_WORD;
                  case (in_type)
                     // Integer and float values pass as given, never scaled or reformatted
                     `PPC_T_S32, `PPC_T_F32: e_sh_reg <= {in_data[31:0], 32'h0};
                     `PPC_T_S64, `PPC_T_F64: begin
                        e_sh_reg  <= in_data;
                        e_cnt_reg <= `PPC_N_DWORD;
                     end
                     `PPC_T_BOOL:  e_sh_reg <= {31'h0, in_data[0], 32'h0};
                     `PPC_T_PBOOL: e_sh_reg <= {in_data[31:0] & pmask, 32'h0};
                     `PPC_T_STR: begin
                        e_sh_reg    <= {e_len, 48'h0};
                        e_cnt_reg   <= `PPC_N_LEN;
                        e_str_reg   <= 1'b1;
                        e_chars_reg <= e_len;
                        e_pad_reg   <= ssize_reg - e_len;
                     end
                     default: e_state_reg <= E_IDLE;
                  endcase
               end
            end
            E_SHIFT: begin
               if (tx_ready) begin
                  e_sh_reg  <= {e_sh_reg[55:0], 8'h00};
                  e_cnt_reg <= e_cnt_reg - 4'h1;
                  if (e_cnt_reg == 4'h1) begin
                     if (e_str_reg & (e_chars_reg != 16'h0)) begin
                        e_state_reg <= E_CHAR;
                     end else if (e_str_reg & (e_pad_reg != 16'h0)) begin
                        e_state_reg <= E_PAD;
                     end else begin
                        e_state_reg <= E_IDLE;
                     end
                  end
               end
            end
            E_CHAR: begin
               if (in_take) begin
                  e_sh_reg    <= {in_data[7:0], 56'h0};
                  e_cnt_reg   <= `PPC_N_CHAR;
                  e_chars_reg <= e_chars_reg - 16'h1;
                  e_state_reg <= E_SHIFT;
               end
            end
            E_PAD: begin
               // Shift register is all zero here, so pad bytes go out as zero
               if (tx_ready) begin
                  e_pad_reg <= e_pad_reg - 16'h1;
                  if (e_pad_reg == 16'h1) begin
                     e_state_reg <= E_IDLE;
                  end
               end
            end
            default: e_state_reg <= E_IDLE;
         endcase
      end
   end

   // ****************************************
   // Decoder
   // ****************************************
   localparam D_IDLE = 4'h1;
   localparam D_COLL = 4'h2;
   localparam D_OUT  = 4'h4;
   localparam D_PAD  = 4'h8;

   reg  [3:0]  d_state_reg;
   reg  [2:0]  d_type_reg;
   reg  [55:0] d_acc_reg;
   reg  [3:0]  d_cnt_reg;
   reg         d_str_reg;
   reg  [15:0] d_chars_reg;
   reg  [15:0] d_pad_reg;
   wire [63:0] full    = {d_acc_reg, rx_byte};
   wire        d_take  = rx_valid & rx_ready;
   wire        d_load  = d_take & (d_state_reg == D_COLL) & (d_cnt_reg == 4'h1);
   wire        d_long  = full[15:0] > ssize_reg;
   wire [15:0] d_len   = d_long ? ssize_reg : full[15:0];
   wire        out_take = out_valid & out_ready;

   assign rx_ready  = dec_en & ((d_state_reg == D_COLL) | (d_state_reg == D_PAD));
   assign out_valid = (d_state_reg == D_OUT);
   assign out_last  = ~(d_str_reg & (d_chars_reg != 16'h0));
   assign dec_done  = (out_take & ~(d_str_reg & ((d_chars_reg != 16'h0) |
                      (d_pad_reg != 16'h0)))) |
                      (d_take & (d_state_reg == D_PAD) & (d_pad_reg == 16'h1));
   assign derr_set  = d_load & (d_type_reg == `PPC_T_STR) & d_long;
   assign d_busy    = (d_state_reg != D_IDLE);

   always @(posedge aclk) begin
      if (!aresetn) begin
         d_state_reg <= D_IDLE;
         d_type_reg  <= `PPC_T_S32;
         d_acc_reg   <= 56'h0;
         d_cnt_reg   <= 4'h0;
         d_str_reg   <= 1'b0;
         d_chars_reg <= 16'h0;
         d_pad_reg   <= 16'h0;
         out_type    <= `PPC_T_S32;
         out_data    <= 64'h0;
         out_sign    <= 1'b0;
         out_exp     <= 11'h0;
         out_frac    <= 53'h0;
         out_bool    <= 1'b0;
      end else begin
         case (d_state_reg)
            D_IDLE: begin
               if (dec_en & rx_valid) begin
                  d_type_reg  <= dec_type;
                  d_str_reg   <= 1'b0;
                  d_state_reg <= D_COLL;
                  case (dec_type)
                     `PPC_T_S64, `PPC_T_F64: d_cnt_reg <= `PPC_N_DWORD;
                     `PPC_T_STR:  d_cnt_reg <= `PPC_N_LEN;
                     `PPC_T_CHAR: d_cnt_reg <= `PPC_N_CHAR;
                     default:     d_cnt_reg <= `PPC_N_WORD;
                  endcase
               end
            end
            D_COLL: begin
               if (d_take) begin
                  d_acc_reg <= full[55:0];
                  d_cnt_reg <= d_cnt_reg - 4'h1;
               end
               if (d_load) begin
                  d_state_reg <= D_OUT;
                  out_type    <= d_type_reg;
                  out_sign    <= 1'b0;
                  out_exp     <= 11'h0;
                  out_frac    <= 53'h0;
                  out_bool    <= full[0];
                  case (d_type_reg)
                     `PPC_T_S32: out_data <= {{32{full[31]}}, full[31:0]};
                     `PPC_T_F32: begin
                        out_data <= {32'h0, full[31:0]};
                        out_sign <= full[31];
                        out_exp  <= {3'h0, full[30:23]};
                        out_frac <= {29'h0, |full[30:23], full[22:0]};
                     end
                     `PPC_T_F64: begin
                        out_data <= full;
                        out_sign <= full[63];
                        out_exp  <= full[62:52];
                        out_frac <= {|full[62:52], full[51:0]};
                     end
                     `PPC_T_BOOL:  out_data <= {63'h0, full[0]};
                     `PPC_T_PBOOL: out_data <= {32'h0, full[31:0]};
                     `PPC_T_STR: begin
                        out_data    <= {48'h0, d_len};
                        d_str_reg   <= 1'b1;
                        d_chars_reg <= d_len;
                        d_pad_reg   <= ssize_reg - d_len;
                     end
                     `PPC_T_CHAR: out_data <= {56'h0, full[7:0]};
                     default:     out_data <= full;
                  endcase
               end
            end
            D_OUT: begin
               if (out_take) begin
                  if (d_str_reg & (d_chars_reg != 16'h0)) begin
                     d_type_reg  <= `PPC_T_CHAR;
                     d_cnt_reg   <= `PPC_N_CHAR;
                     d_chars_reg <= d_chars_reg - 16'h1;
                     d_state_reg <= D_COLL;
                  end else if (d_str_reg & (d_pad_reg != 16'h0)) begin
                     d_state_reg <= D_PAD;
                  end else begin
                     d_state_reg <= D_IDLE;
                  end
               end
            end
            D_PAD: begin
               // Pad bytes are consumed and dropped
               if (d_take) begin
                  d_pad_reg <= d_pad_reg - 16'h1;
                  if (d_pad_reg == 16'h1) begin
                     d_state_reg <= D_IDLE;
                  end
               end
            end
            default: d_state_reg <= D_IDLE;
         endcase
      end
   end

endmodule

//--- test/ppc_far.sv
// Far-side payload byte buffer model for the codec
`timescale 1ns/10ps
module ppc_far (
   input  wire        aclk,
   input  wire        aresetn,
   input  wire        slow,
   input  wire        tx_valid,
   output logic       tx_ready,
   input  wire  [7:0] tx_byte,
   input  wire        tx_last,
   output logic       rx_valid,
   input  wire        rx_ready,
   output logic [7:0] rx_byte
);
   logic [7:0] txq[$];
   logic [7:0] rxq[$];
   int         n_last = 0;
   logic       tick = 1'b0;
   always @(posedge aclk) begin
      tick <= ~tick;
      if (!aresetn) begin
         tx_ready <= 1'b0;
         rx_valid <= 1'b0;
         rx_byte  <= 8'h00;
      end else begin
         // Log bytes and element ends
         if (tx_valid && tx_ready) begin
            txq.push_back(tx_byte);
            if (tx_last) n_last++;
         end
         tx_ready <= !slow || tick;
         // Hold a byte until taken; an idle line toggles
         if (!rx_valid || rx_ready) begin
            if (rxq.size() > 0 && (!slow || tick)) begin
               rx_valid <= 1'b1;
               rx_byte  <= rxq.pop_front();
            end else begin
               rx_valid <= 1'b0;
               rx_byte  <= ~rx_byte;
            end
         end
      end
   end
endmodule

//--- test/ppc_codec_asserts.sv
// Assertion checker for the payload primitive codec
`timescale 1ns/10ps
`include "ppc_consts.vh"
module ppc_codec_asserts (
   input wire        aclk,
   input wire        aresetn,
   input wire        in_valid,
   input wire        in_ready,
   input wire [2:0]  in_type,
   input wire [63:0] in_data,
   input wire        tx_valid,
   input wire        tx_ready,
   input wire [7:0]  tx_byte,
   input wire        tx_last,
   input wire        out_valid,
   input wire        out_ready,
   input wire [2:0]  out_type,
   input wire [63:0] out_data,
   input wire        out_sign,
   input wire [10:0] out_exp,
   input wire [52:0] out_frac,
   input wire        out_bool
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence s_take(t);
      in_valid && in_ready && in_type == t;
   endsequence
   sequence s_mid3;
      (tx_valid && tx_ready && !tx_last)[*3];
   endsequence
   a_tx_hold: assert property (
      tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte) && $stable(tx_last))
      else $error("tx byte changed while stalled");
   a_out_hold: assert property (
      out_valid && !out_ready |=> out_valid && $stable(out_data) && $stable(out_type))
      else $error("output changed while stalled");
   a_busy_after_take: assert property (
      s_take(`PPC_T_S64) |=> !in_ready)
      else $error("element taken while busy");
   a_s32_msb_first: assert property (
      s_take(`PPC_T_S32) |=> tx_valid && tx_byte == $past(in_data[31:24]))
      else $error("s32 msb not first");
   a_s32_four_bytes: assert property (
      s_take(`PPC_T_S32) ##1 s_mid3 |=> tx_valid && tx_last)
      else $error("s32 element not four bytes");
   a_s32_sign_ext: assert property (
      out_valid && out_type == `PPC_T_S32 |-> out_data[63:32] == {32{out_data[31]}})
      else $error("s32 not sign extended");
   a_bool_bit0: assert property (
      out_valid && out_type == `PPC_T_BOOL |-> out_bool == out_data[0])
      else $error("boolean not bit 0");
   a_f32_fields: assert property (
      out_valid && out_type == `PPC_T_F32 |-> out_sign == out_data[31]
      && out_exp == {3'h0, out_data[30:23]}
      && out_frac == {29'h0, |out_data[30:23], out_data[22:0]})
      else $error("f32 fields wrong");
   a_f64_fields: assert property (
      out_valid && out_type == `PPC_T_F64 |-> out_sign == out_data[63]
      && out_exp == out_data[62:52] && out_frac == {|out_data[62:52], out_data[51:0]})
      else $error("f64 fields wrong");
endmodule
bind ppc_codec ppc_codec_asserts i_ppc_codec_asserts (.aclk(aclk), .aresetn(aresetn),
   .in_valid(in_valid), .in_ready(in_ready), .in_type(in_type), .in_data(in_data),
   .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_byte(tx_byte), .tx_last(tx_last),
   .out_valid(out_valid), .out_ready(out_ready), .out_type(out_type),
   .out_data(out_data), .out_sign(out_sign), .out_exp(out_exp), .out_frac(out_frac),
   .out_bool(out_bool));

//--- test/testbench.sv
// Self-checking testbench for the payload primitive codec
`timescale 1ns/10ps
`include "ppc_consts.vh"
module testbench;
   logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
   logic        s_axi_arvalid, s_axi_rready, in_valid, out_ready, slow;
   logic [4:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata;
   logic [3:0]  s_axi_wstrb;
   logic [2:0]  in_type, dec_type;
   logic [63:0] in_data;
   logic [5:0]  in_bool_count;
   wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire  [1:0]  s_axi_bresp, s_axi_rresp;
   wire  [31:0] s_axi_rdata;
   wire         in_ready, tx_valid, tx_ready, tx_last, rx_valid, rx_ready;
   wire         out_valid, out_sign, out_bool, out_last;
   wire  [7:0]  tx_byte, rx_byte;
   wire  [2:0]  out_type;
   wire  [63:0] out_data;
   wire  [10:0] out_exp;
   wire  [52:0] out_frac;
   int          n_fail = 0;
   int          compares = 0;
   ppc_codec i_ppc_codec (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready), .in_valid(in_valid), .in_ready(in_ready),
      .in_type(in_type), .in_data(in_data), .in_bool_count(in_bool_count),
      .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_byte(tx_byte), .tx_last(tx_last),
      .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_byte(rx_byte), .dec_type(dec_type),
      .out_valid(out_valid), .out_ready(out_ready), .out_type(out_type),
      .out_data(out_data), .out_sign(out_sign), .out_exp(out_exp), .out_frac(out_frac),
      .out_bool(out_bool), .out_last(out_last));
   ppc_far i_ppc_far (.aclk(aclk), .aresetn(aresetn), .slow(slow), .tx_valid(tx_valid),
      .tx_ready(tx_ready), .tx_byte(tx_byte), .tx_last(tx_last), .rx_valid(rx_valid),
      .rx_ready(rx_ready), .rx_byte(rx_byte));
   // ****************************************
   // Bus, stream and compare tasks
   // ****************************************
   task chk(input logic [63:0] got, input logic [63:0] exp);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task wrap_up;
      $display("Counts: compares=%0d n_fail=%0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task axi_wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] er);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      chk(64'(s_axi_bresp), 64'(er));
   endtask
   task axi_rd(input logic [4:0] a, input logic [31:0] ed, input logic [1:0] er);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      chk(64'(s_axi_rdata), 64'(ed));
      chk(64'(s_axi_rresp), 64'(er));
   endtask
   task offer(input logic [2:0] t, input logic [63:0] d, input logic [5:0] c);
      in_type <= t;
      in_data <= d;
      in_bool_count <= c;
      in_valid <= 1'b1;
      do @(posedge aclk); while (!in_ready);
      in_valid <= 1'b0;
      @(posedge aclk);
   endtask
   // Expect n bytes of e, most significant first
   task drain(input logic [63:0] e, input int n);
      while (i_ppc_far.txq.size() < n) @(posedge aclk);
      for (int i = n - 1; i >= 0; i--) chk(64'(i_ppc_far.txq.pop_front()), 64'(e[8*i +: 8]));
   endtask
   task enc(input logic [2:0] t, input logic [63:0] d, input logic [5:0] c,
            input logic [63:0] e, input int n);
      offer(t, d, c);
      drain(e, n);
   endtask
   task feed(input logic [2:0] t, input logic [63:0] d, input int n);
      dec_type <= t;
      for (int i = n - 1; i >= 0; i--) i_ppc_far.rxq.push_back(d[8*i +: 8]);
   endtask
   // Stall one cycle so the held output is exercised
   task take(input logic [2:0] et, input logic [63:0] ed, input logic [52:0] ef);
      do @(posedge aclk); while (!out_valid);
      chk(64'(out_type), 64'(et));
      chk(out_data, ed);
      chk(64'(out_last), 64'(et != `PPC_T_STR));
      if (et == `PPC_T_F32 || et == `PPC_T_F64) chk(64'(out_frac), 64'(ef));
      @(posedge aclk);
      out_ready <= 1'b1;
      @(posedge aclk);
      out_ready <= 1'b0;
   endtask
   // ****************************************
   // Clock, watchdog and tests
   // ****************************************
   initial begin
      aclk = 1'b0;
      forever #25 aclk = ~aclk;
   end
   initial begin
      #(50 * 20000);
      n_fail++;
      wrap_up;
   end
   initial begin
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 4'h0;
      {in_valid, out_ready, slow} = 3'h0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, in_type, dec_type} = 48'h0;
      {in_data, in_bool_count} = 70'h0;
      {s_axi_bready, s_axi_rready, s_axi_wstrb} = 6'h3F;
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      axi_rd(`PPC_A_CTRL, 32'h00000003, `PPC_RESP_OK);
      axi_rd(`PPC_A_SSIZE, 32'h00000020, `PPC_RESP_OK);
      axi_rd(5'h14, 32'h00000000, `PPC_RESP_ERR);
      axi_wr(5'h14, 32'h00000001, `PPC_RESP_ERR);
      axi_wr(`PPC_A_SSIZE, 32'h00000003, `PPC_RESP_OK);
      $display("Register test done");
      enc(`PPC_T_S32, 64'hFFFFFFFF80000001, 6'h00, 64'h80000001, 4);
      slow <= 1'b1;
      enc(`PPC_T_S64, 64'h0123456789ABCDEF, 6'h00, 64'h0123456789ABCDEF, 8);
      enc(`PPC_T_F32, 64'hBF800001, 6'h00, 64'hBF800001, 4);
      enc(`PPC_T_F64, 64'hC00FFFFFFFFFFFFF, 6'h00, 64'hC00FFFFFFFFFFFFF, 8);
      enc(`PPC_T_BOOL, 64'h1, 6'h00, 64'h00000001, 4);
      enc(`PPC_T_PBOOL, 64'hFFFFFFFFFFFFFFFF, 6'h05, 64'h0000001F, 4);
      enc(`PPC_T_PBOOL, 64'hFFFFFFFFFFFFFFFF, 6'h21, 64'hFFFFFFFF, 4);
      offer(`PPC_T_STR, 64'h2, 6'h00);
      offer(`PPC_T_CHAR, 64'h41, 6'h00);
      offer(`PPC_T_CHAR, 64'h42, 6'h00);
      drain(64'h0002414200, 5);
      chk(64'(i_ppc_far.n_last), 64'h8);
      axi_rd(`PPC_A_ECNT, 32'h00000008, `PPC_RESP_OK);
      $display("Encoder test done");
      feed(`PPC_T_S32, 64'hFFFFFFFE, 4);
      take(`PPC_T_S32, 64'hFFFFFFFFFFFFFFFE, 53'h0);
      feed(`PPC_T_S64, 64'h8000000000000001, 8);
      take(`PPC_T_S64, 64'h8000000000000001, 53'h0);
      feed(`PPC_T_F32, 64'h00400000, 4);
      take(`PPC_T_F32, 64'h00400000, 53'h400000);
      feed(`PPC_T_F64, 64'hBFF8000000000000, 8);
      take(`PPC_T_F64, 64'hBFF8000000000000, 53'h18000000000000);
      feed(`PPC_T_BOOL, 64'h1, 4);
      take(`PPC_T_BOOL, 64'h1, 53'h0);
      feed(`PPC_T_STR, 64'h00015A0000, 5);
      take(`PPC_T_STR, 64'h1, 53'h0);
      take(`PPC_T_CHAR, 64'h5A, 53'h0);
      $display("Decoder test done");
      wrap_up;
   end
endmodule
